// file: design/ipgc_top.sv
// Gain control register bank for four input amplifiers and two input mixers.
// Assumes a single-cycle register port and zero-cross pulses synchronous to CLK.
`timescale 1ns/1ns

// Contract
// - First-pair strobe applies both first gains together
// - Codes written without strobe stay held only while no update is pending
// - Crossing bit selects immediate or zero-cross change
// - Pending crossing update applies at timeout
// - Mute bit per amplifier, resets muted
// - Five-bit linear gain code, resets to 0 dB
// - Bit 9 enables left mixer and voice
// - Bit 8 enables right mixer and voice
module ipgc_top #(
  parameter int TIMEOUT_COUNT = ipgc_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Zero-cross detector pulses, one per amplifier: 0 left a, 1 right a, 2 left b, 3 right b
  input wire logic [3:0] ZERO_CROSS,
  // Active amplifier controls
  output logic [19:0] ACTIVE_GAIN,
  output logic [3:0] AMP_SILENCE,
  // Mixer enables, each also enables the voice differential input
  output logic LEFT_MIXER_ON,
  output logic RIGHT_MIXER_ON,
  // Update still waiting for a zero crossing
  output logic [3:0] UPDATE_PENDING
);

  localparam int CW = $clog2(TIMEOUT_COUNT + 1);

  ipgc_pkg::ipgc_amp_type held_reg [4];
  logic [4:0] active_gain_reg [4];
  logic [3:0] pend_reg;
  logic [CW-1:0] tmo_reg [4];
  logic left_mixer_on_reg;
  logic right_mixer_on_reg;
  logic [3:0] apply;
  logic [3:0] wr_hit;

  // Address decode per amplifier register
  always_comb begin
    wr_hit[0] = WR && (ADDR == ipgc_pkg::LEFT_FIRST_PAIR_GAIN_ADDR);
    wr_hit[1] = WR && (ADDR == ipgc_pkg::RIGHT_FIRST_PAIR_GAIN_ADDR);
    wr_hit[2] = WR && (ADDR == ipgc_pkg::LEFT_SECOND_PAIR_GAIN_ADDR);
    wr_hit[3] = WR && (ADDR == ipgc_pkg::RIGHT_SECOND_PAIR_GAIN_ADDR);
  end

  // A strobe of one on either register of a pair applies both members
  always_comb begin
    apply[0] = (wr_hit[0] || wr_hit[1]) && WDATA[ipgc_pkg::APPLY_BIT];
    apply[1] = apply[0];
    apply[2] = (wr_hit[2] || wr_hit[3]) && WDATA[ipgc_pkg::APPLY_BIT];
    apply[3] = apply[2];
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_amp
      // Held fields take every write; strobe is not stored
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          held_reg[g].silence <= ipgc_pkg::SILENCE_RESET;
          held_reg[g].crossing_sel <= ipgc_pkg::CROSSING_RESET;
          held_reg[g].gain_code <= ipgc_pkg::GAIN_RESET;
        end else if (wr_hit[g]) begin
          held_reg[g].silence <= WDATA[ipgc_pkg::SILENCE_BIT];
          held_reg[g].crossing_sel <= WDATA[ipgc_pkg::CROSSING_BIT];
          held_reg[g].gain_code <= WDATA[ipgc_pkg::GAIN_MSB:0];
        end
      end

      // Active gain loads on strobe, or later on crossing or timeout.
      // A new strobe with crossing selected while pending restarts the wait with the newest code.
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          active_gain_reg[g] <= ipgc_pkg::GAIN_RESET;
          pend_reg[g] <= 1'b0;
          tmo_reg[g] <= '0;
        end else if (apply[g]) begin
          // Crossing select reads the value written in this same cycle
          if (wr_hit[g] ? WDATA[ipgc_pkg::CROSSING_BIT] : held_reg[g].crossing_sel) begin
            pend_reg[g] <= 1'b1;
            tmo_reg[g] <= '0;
          end else begin
            active_gain_reg[g] <= wr_hit[g] ? WDATA[ipgc_pkg::GAIN_MSB:0]
                                            : held_reg[g].gain_code;
            pend_reg[g] <= 1'b0;
          end
        end else if (pend_reg[g]) begin
          if (ZERO_CROSS[g] || tmo_reg[g] == CW'(TIMEOUT_COUNT - 1)) begin
            active_gain_reg[g] <= held_reg[g].gain_code;
            pend_reg[g] <= 1'b0;
          end else begin
            tmo_reg[g] <= tmo_reg[g] + CW'(1);
          end
        end
      end

      // Outputs straight from flops; mute acts at once
      assign ACTIVE_GAIN[g*5 +: 5] = active_gain_reg[g];
      assign AMP_SILENCE[g] = held_reg[g].silence;
    end
  endgenerate

  assign UPDATE_PENDING = pend_reg;

  // Mixer enables in the second power register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      left_mixer_on_reg <= ipgc_pkg::MIXER_RESET;
      right_mixer_on_reg <= ipgc_pkg::MIXER_RESET;
    end else if (WR && ADDR == ipgc_pkg::POWER_CONTROL_TWO_ADDR) begin
      left_mixer_on_reg <= WDATA[ipgc_pkg::LEFT_MIXER_BIT];
      right_mixer_on_reg <= WDATA[ipgc_pkg::RIGHT_MIXER_BIT];
    end
  end

  assign LEFT_MIXER_ON = left_mixer_on_reg;
  assign RIGHT_MIXER_ON = right_mixer_on_reg;

  // Read data one cycle after the strobe; strobe bit reads zero
  function automatic logic [15:0] amp_word(input ipgc_pkg::ipgc_amp_type a);
    amp_word = {8'h00, a.silence, a.crossing_sel, 1'b0, a.gain_code};
  endfunction

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      unique case (ADDR)
        ipgc_pkg::POWER_CONTROL_TWO_ADDR:
          RDATA <= {6'h00, left_mixer_on_reg, right_mixer_on_reg, 8'h00};
        ipgc_pkg::LEFT_FIRST_PAIR_GAIN_ADDR: RDATA <= amp_word(held_reg[0]);
        ipgc_pkg::RIGHT_FIRST_PAIR_GAIN_ADDR: RDATA <= amp_word(held_reg[1]);
        ipgc_pkg::LEFT_SECOND_PAIR_GAIN_ADDR: RDATA <= amp_word(held_reg[2]);
        ipgc_pkg::RIGHT_SECOND_PAIR_GAIN_ADDR: RDATA <= amp_word(held_reg[3]);
        default: RDATA <= 16'h0000; // Unmapped reads zero
      endcase
    end else begin
      RDATA <= 16'h0000;
    end
  end

endmodule

// file: pkg/ipgc_pkg.sv
// Package for the input amplifier gain control register bank.
// Assumes a 16-bit register port with word offsets and a 100 MHz clock.
package ipgc_pkg;
  // Register offsets
  localparam logic [7:0] POWER_CONTROL_TWO_ADDR = 8'h02;
  localparam logic [7:0] RIGHT_FIRST_PAIR_GAIN_ADDR = 8'h1a;
  localparam logic [7:0] RIGHT_SECOND_PAIR_GAIN_ADDR = 8'h1b;
  localparam logic [7:0] LEFT_FIRST_PAIR_GAIN_ADDR = 8'h18;
  localparam logic [7:0] LEFT_SECOND_PAIR_GAIN_ADDR = 8'h19;
  // Field positions
  localparam int APPLY_BIT = 8;
  localparam int SILENCE_BIT = 7;
  localparam int CROSSING_BIT = 6;
  localparam int GAIN_MSB = 4;
  localparam int LEFT_MIXER_BIT = 9;
  localparam int RIGHT_MIXER_BIT = 8;
  // Reset values
  localparam logic [4:0] GAIN_RESET = 5'h0b;
  localparam logic SILENCE_RESET = 1'b1;
  localparam logic CROSSING_RESET = 1'b0;
  localparam logic MIXER_RESET = 1'b0;
  // Zero-cross timeout in microseconds and derived cycles at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT_US = 10000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;

  // Per-amplifier control fields
  typedef struct packed {
    logic silence;
    logic crossing_sel;
    logic [4:0] gain_code;
  } ipgc_amp_type;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ipgc_req_type;
endpackage

// file: tb/ipgc_asserts.sv
// Checker for the gain control bank, watching only the top module's ports.
// Assumes a short timeout parameter handed down by the bind.
`timescale 1ns/1ns
module ipgc_asserts #(parameter int TIMEOUT_COUNT = 8) (
  // Clock, reset and register port
  input wire logic CLK, input wire logic RST_N,
  input wire logic [7:0] ADDR, input wire logic [15:0] WDATA,
  input wire logic WR, input wire logic RD, input wire logic [15:0] RDATA,
  // Amplifier and mixer side
  input wire logic [3:0] ZERO_CROSS, input wire logic [19:0] ACTIVE_GAIN,
  input wire logic [3:0] AMP_SILENCE, input wire logic LEFT_MIXER_ON,
  input wire logic RIGHT_MIXER_ON, input wire logic [3:0] UPDATE_PENDING);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Writes to the two right-channel gain registers
  sequence wr_a; WR && ADDR == 8'h1a; endsequence
  sequence wr_b; WR && ADDR == 8'h1b; endsequence
  sequence arm_b; wr_b ##0 WDATA[8] && WDATA[6]; endsequence
  silence_a: assert property (wr_a |=> AMP_SILENCE[1] == $past(WDATA[7]))
    else $error("mute bit not taken");
  left_mix_a: assert property (WR && ADDR == 8'h02 |=> LEFT_MIXER_ON == $past(WDATA[9]))
    else $error("left mixer enable wrong");
  right_mix_a: assert property (WR && ADDR == 8'h02 |=> RIGHT_MIXER_ON == $past(WDATA[8]))
    else $error("right mixer enable wrong");
  held_code_a: assert property (wr_a ##0 !WDATA[8] && UPDATE_PENDING == 4'h0 |=> $stable(ACTIVE_GAIN))
    else $error("gain changed without strobe");
  apply_first_a: assert property (wr_a ##0 WDATA[8] && !WDATA[6] && !UPDATE_PENDING[1]
    |=> ACTIVE_GAIN[9:5] == $past(WDATA[4:0])) else $error("first pair not applied");
  apply_second_a: assert property (wr_b ##0 WDATA[8] && !WDATA[6] && !UPDATE_PENDING[3]
    |=> ACTIVE_GAIN[19:15] == $past(WDATA[4:0])) else $error("second pair not applied");
  cross_wait_a: assert property (arm_b |=> UPDATE_PENDING[3] && $stable(ACTIVE_GAIN[19:15]))
    else $error("crossing update not held");
  cross_done_a: assert property (UPDATE_PENDING[3] && ZERO_CROSS[3] |-> ##[1:2] !UPDATE_PENDING[3])
    else $error("crossing did not apply");
  timeout_a: assert property ($rose(UPDATE_PENDING[3]) |-> ##[1:12] !UPDATE_PENDING[3])
    else $error("timeout did not apply");
  strobe_read_a: assert property (RD && ADDR == 8'h1a |=> RDATA[15:8] == 8'h00)
    else $error("strobe bit read back");
endmodule
bind ipgc_top ipgc_asserts #(.TIMEOUT_COUNT(TIMEOUT_COUNT)) chk_i (.*);

// file: tb/input_pga_gain_control_bench.sv
// Bench for the gain control bank: register tasks, crossing pulses, verdict.
// Assumes the timeout is shortened to 8 cycles.
`timescale 1ns/1ns
module input_pga_gain_control_bench;
  logic CLK = 0, RST_N = 0, WR = 0, RD = 0;
  logic [7:0] ADDR = 8'h00;
  logic [15:0] WDATA = 16'h0000, RDATA;
  logic [3:0] ZERO_CROSS = 4'h0, AMP_SILENCE, UPDATE_PENDING;
  logic [19:0] ACTIVE_GAIN;
  logic LEFT_MIXER_ON, RIGHT_MIXER_ON;
  logic [15:0] mix [4] = '{16'h0200, 16'h0100, 16'h0300, 16'h0000};
  int fails = 0, n_checks = 0, cyc = 0;
  ipgc_top #(.TIMEOUT_COUNT(8)) dut (.*);
  initial forever #5 CLK = ~CLK;
  // Watchdog, far above the fewer than one hundred cycles the tests need
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle write; returns just after the taking edge so outputs settle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(20'(RDATA), 20'(e));
  endtask
  initial begin
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    #1 chk(20'({AMP_SILENCE, LEFT_MIXER_ON, RIGHT_MIXER_ON, UPDATE_PENDING}), 20'h003c0);
    chk(ACTIVE_GAIN, 20'h5ad6b);
    rd(8'h1a, 16'h008b);
    wr(8'h1a, 16'h001f);
    chk(ACTIVE_GAIN, 20'h5ad6b);
    chk(20'(AMP_SILENCE), 20'h0000d);
    rd(8'h1a, 16'h001f);
    wr(8'h18, 16'h0100);
    chk(20'(ACTIVE_GAIN[9:0]), 20'h003e0);
    wr(8'h1a, 16'h0005);
    chk(20'(ACTIVE_GAIN[9:0]), 20'h003e0);
    rd(8'h1a, 16'h0005);
    wr(8'h1a, 16'h0105);
    chk(20'(ACTIVE_GAIN[9:0]), 20'h000a0);
    wr(8'h19, 16'h0003);
    wr(8'h1b, 16'h0114);
    chk(20'(ACTIVE_GAIN[19:10]), 20'h00283);
    // Crossing armed: gain must wait for the pulse on amplifier 3
    wr(8'h1b, 16'h0148);
    chk(20'({ACTIVE_GAIN[19:15], UPDATE_PENDING}), 20'h00148);
    @(posedge CLK) ZERO_CROSS <= 4'h8;
    @(posedge CLK) ZERO_CROSS <= 4'h0;
    repeat (2) @(posedge CLK);
    #1 chk(20'({ACTIVE_GAIN[19:15], UPDATE_PENDING}), 20'h00080);
    wr(8'h1b, 16'h0156);
    repeat (12) @(posedge CLK);
    #1 chk(20'({ACTIVE_GAIN[19:15], UPDATE_PENDING}), 20'h00160);
    foreach (mix[i]) begin
      wr(8'h02, mix[i]);
      chk(20'({LEFT_MIXER_ON, RIGHT_MIXER_ON}), 20'(mix[i][9:8]));
      rd(8'h02, mix[i]);
    end
    wr(8'h33, 16'hffff);
    rd(8'h33, 16'h0000);
    complete_run();
  end
endmodule
